// [verilog/dcrtm_timer.sv]
// Purpose: 16-bit pwm, event counter and input capture timer
// Assumes: AHB-Lite slave, zero wait states, word transfers only
// Notes:   master clock is the system clock; instruction rate is a
//          divided enable pulse
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`default_nettype none

module dcrtm_timer #(
   parameter int INST_DIV = dcrtm_pkg::INST_DIV,
   parameter int ADDR_W   = 12
) (
   // clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst_n,
   // AHB-Lite slave
   input  wire logic              i_hsel,
   input  wire logic [ADDR_W-1:0] i_haddr,
   input  wire logic [1:0]        i_htrans,
   input  wire logic              i_hwrite,
   input  wire logic [2:0]        i_hsize,
   input  wire logic [31:0]       i_hwdata,
   input  wire logic              i_hready,
   output logic      [31:0]       o_hrdata,
   output logic                   o_hreadyout,
   output logic                   o_hresp,
   // timer pins
   input  wire logic              i_timer_pin_a,
   output logic                   o_timer_pin_a,
   output logic                   o_timer_pin_a_oe,
   input  wire logic              i_timer_pin_b,
   // interrupt requests
   output logic                   o_irq_a,
   output logic                   o_irq_b
);

   localparam int DIV_W = (INST_DIV > 1) ? $clog2(INST_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INST_DIV - 1);
   localparam int CTRL_WIDTH = dcrtm_pkg::CTRL_W;

   typedef struct packed {
      logic [DIV_W-1:0] div;      // instruction rate divider
      logic [15:0]      count;
      logic [15:0]      sup_a;
      logic [15:0]      sup_b;
      logic             run_flag; // run, or underflow pending in capture
      logic             pend_a;
      logic             pend_b;
      logic             en_a;
      logic             en_b;
      logic [2:0]       mode;     // {mode_bit_3, mode_bit_2, mode_bit_1}
      logic             fast;
      logic             sel_b;    // next pwm reload comes from b
      logic             pwm_out;
      logic             dp_wr;    // write data phase pending
      logic [2:0]       dp_idx;
      logic [31:0]      rdata;
   } dcrtm_state_t;

   dcrtm_state_t st;
   dcrtm_state_t next_st;

   logic [1:0]  rst_pipe;
   logic        rst_n;
   logic        is_capture;
   logic        is_pwm;
   logic        is_event;
   logic        inst_pulse;
   logic        tick;
   logic        cap_a;
   logic        cap_b;
   logic        evt_a;
   logic        addr_ok;
   logic        take;
   logic        cnt_wr;
   logic        at_zero;
   logic [CTRL_WIDTH-1:0] ctrl_word;

   dcrtm_edge_if edges ();

   // ***********************************************************
   // reset release
   // ***********************************************************
   // assert at once, release two clocks late to avoid metastability
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // ***********************************************************
   // mode decode and counting rate
   // ***********************************************************
   // the three mode bits decode fully, every code picks one mode
   assign is_capture = st.mode[1];
   assign is_pwm     = (st.mode == dcrtm_pkg::MODE_PWM_TOGL) ||
                       (st.mode == dcrtm_pkg::MODE_PWM_NOTG);
   assign is_event   = (st.mode == dcrtm_pkg::MODE_EVT_RISE) ||
                       (st.mode == dcrtm_pkg::MODE_EVT_FALL);
   assign inst_pulse = (st.div == DIV_LAST);
   // fast mode counts every master clock, so values move each cycle
   assign tick       = st.fast | inst_pulse;

   // pin edge sampler on the counting tick
   assign edges.tick  = tick;
   assign edges.pin_a = i_timer_pin_a;
   assign edges.pin_b = i_timer_pin_b;

   dcrtm_edge_sampler u_sampler (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (rst_n),
      .edges     (edges.sampler)
   );

   // per-pin polarity: bit 1 of mode for pin a, bit 3 for pin b
   assign cap_a = is_capture &
                  (st.mode[0] ? edges.fall_a : edges.rise_a);
   assign cap_b = is_capture &
                  (st.mode[2] ? edges.fall_b : edges.rise_b);
   assign evt_a = st.mode[0] ? edges.fall_a : edges.rise_a;

   // ***********************************************************
   // bus decode
   // ***********************************************************
   assign addr_ok = (i_haddr[ADDR_W-1:5] == '0) &&
                    (i_haddr[4:2] <= dcrtm_pkg::IDX_CLR) &&
                    (i_haddr[1:0] == 2'h0);
   // seq is taken like nonseq, though only single transfers are expected
   assign take    = i_hsel & i_hready & (i_htrans == dcrtm_pkg::HTRANS_NSEQ
                    || i_htrans == 2'h3);

   // ***********************************************************
   // counter helpers
   // ***********************************************************
   // a software count write in this data phase beats the decrement
   assign cnt_wr  = st.dp_wr && (st.dp_idx == dcrtm_pkg::IDX_COUNT);
   // zero seen at a tick means the next step underflows or reloads
   assign at_zero = (st.count == 16'h0000);

   // control register image as seen by software
   // set and clear ops work on this image, so no other bit is lost
   always_comb begin
      ctrl_word = '0;
      ctrl_word[dcrtm_pkg::BIT_RUN]    = st.run_flag;
      ctrl_word[dcrtm_pkg::BIT_PEND_A] = st.pend_a;
      ctrl_word[dcrtm_pkg::BIT_PEND_B] = st.pend_b;
      ctrl_word[dcrtm_pkg::BIT_EN_A]   = st.en_a;
      ctrl_word[dcrtm_pkg::BIT_EN_B]   = st.en_b;
      ctrl_word[dcrtm_pkg::BIT_MODE_LO +: 3] = st.mode;
      ctrl_word[dcrtm_pkg::BIT_FAST]   = st.fast;
   end

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      logic [CTRL_WIDTH-1:0] cw;
      logic                  wr_now;
      next_st = st;
      cw      = ctrl_word;
      wr_now  = st.dp_wr;

      // instruction rate divider runs always
      next_st.div = inst_pulse ? '0 : st.div + DIV_W'(1);

      // software side first, so hardware events below win over clears
      if (wr_now) begin
         unique case (st.dp_idx)
            dcrtm_pkg::IDX_CTRL:  cw = i_hwdata[CTRL_WIDTH-1:0];
            dcrtm_pkg::IDX_SET:   cw = ctrl_word |
                                       i_hwdata[CTRL_WIDTH-1:0];
            dcrtm_pkg::IDX_CLR:   cw = ctrl_word &
                                       ~i_hwdata[CTRL_WIDTH-1:0];
            dcrtm_pkg::IDX_COUNT: next_st.count = i_hwdata[15:0];
            dcrtm_pkg::IDX_SUP_A: next_st.sup_a = i_hwdata[15:0];
            dcrtm_pkg::IDX_SUP_B: next_st.sup_b = i_hwdata[15:0];
            default: ;
         endcase
      end
      // flags change only by software writes here
      next_st.run_flag = cw[dcrtm_pkg::BIT_RUN];
      next_st.pend_a   = cw[dcrtm_pkg::BIT_PEND_A];
      next_st.pend_b   = cw[dcrtm_pkg::BIT_PEND_B];
      next_st.en_a     = cw[dcrtm_pkg::BIT_EN_A];
      next_st.en_b     = cw[dcrtm_pkg::BIT_EN_B];
      next_st.mode     = cw[dcrtm_pkg::BIT_MODE_LO +: 3];
      next_st.fast     = cw[dcrtm_pkg::BIT_FAST];

      // leaving pwm forgets the alternation, so a later start
      // reloads from a first
      if (!is_pwm) begin
         next_st.sel_b = 1'b0;
      end

      // counter engine; a same-cycle software count write is kept
      if (is_capture) begin
         // free running, captures and underflows never stop it
         if (tick) begin
            if (!cnt_wr) begin
               next_st.count = st.count - 16'h0001;
            end
            if (at_zero) begin
               next_st.run_flag = 1'b1;
            end
         end
         if (cap_a) begin
            next_st.sup_a  = st.count;
            next_st.pend_a = 1'b1;
         end
         if (cap_b) begin
            next_st.sup_b  = st.count;
            next_st.pend_b = 1'b1;
         end
      end else if (is_pwm) begin
         if (!st.run_flag) begin
            // restart always begins with a reload from a
            next_st.sel_b = 1'b0;
         end else if (tick) begin
            // the tick that sees zero loads a span instead of counting
            if (at_zero) begin
               if (st.sel_b) begin
                  next_st.count  = st.sup_b;
                  next_st.pend_b = 1'b1;
               end else begin
                  next_st.count  = st.sup_a;
                  next_st.pend_a = 1'b1;
               end
               next_st.sel_b = ~st.sel_b;
               if (st.mode == dcrtm_pkg::MODE_PWM_TOGL) begin
                  next_st.pwm_out = ~st.pwm_out;
               end
            end else begin
               next_st.count = st.count - 16'h0001;
            end
            if (cnt_wr) begin
               next_st.count = i_hwdata[15:0];
            end
         end
      end else if (is_event) begin
         if (st.run_flag && evt_a) begin
            if (!cnt_wr) begin
               next_st.count = st.count - 16'h0001;
            end
            if (at_zero) begin
               next_st.pend_a = 1'b1;
            end
         end
         // pin b rising edges latch even while halted, b is an independent input
         if (edges.rise_b) begin
            next_st.pend_b = 1'b1;
         end
      end

      // address phase: reads are registered, writes wait for data
      // a write of another size is dropped; reads answer every size
      next_st.dp_wr = 1'b0;
      if (take && addr_ok) begin
         next_st.dp_wr  = i_hwrite && (i_hsize == dcrtm_pkg::HSIZE_WORD);
         next_st.dp_idx = i_haddr[4:2];
      end
      if (take && !i_hwrite) begin
         // plain copy, so reads cannot disturb the count
         next_st.rdata = 32'h0000_0000;
         if (addr_ok) begin
            unique case (i_haddr[4:2])
               dcrtm_pkg::IDX_CTRL:  next_st.rdata =
                                        {{(32-CTRL_WIDTH){1'b0}}, ctrl_word};
               dcrtm_pkg::IDX_COUNT: next_st.rdata = {16'h0000, st.count};
               dcrtm_pkg::IDX_SUP_A: next_st.rdata = {16'h0000, st.sup_a};
               dcrtm_pkg::IDX_SUP_B: next_st.rdata = {16'h0000, st.sup_b};
               default:              next_st.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ***********************************************************
   // state register
   // ***********************************************************
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st         <= '0;
         // only the counter leaves reset at a non-zero value
         st.count   <= dcrtm_pkg::COUNT_RST;
         st.fast    <= dcrtm_pkg::CTRL_RST[dcrtm_pkg::BIT_FAST];
      end else begin
         st <= next_st;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   // zero wait states keep the slave simple; response is always okay
   // read data holds until the next read; writes never move it
   assign o_hrdata    = st.rdata;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   // pin a drives only in toggling pwm mode, it is an input otherwise
   assign o_timer_pin_a    = st.pwm_out;
   assign o_timer_pin_a_oe = (st.mode == dcrtm_pkg::MODE_PWM_TOGL);

   // interrupt requests gated by their enables
   // in capture mode an underflow shares request a with pin a captures
   assign o_irq_a = st.en_a & (st.pend_a |
                    (is_capture & st.run_flag));
   assign o_irq_b = st.en_b & st.pend_b;

endmodule

`default_nettype wire

// [verilog/dcrtm_pkg.sv]
// Purpose: shared constants of the dual reload capture timer
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   offsets are byte addresses; indexes are offset / 4
`default_nettype none

package dcrtm_pkg;

   // ***********************************************************
   // register map
   // ***********************************************************
   localparam logic [2:0]  IDX_CTRL    = 3'h0; // control and flags
   localparam logic [2:0]  IDX_COUNT   = 3'h1; // 16-bit counter
   localparam logic [2:0]  IDX_SUP_A   = 3'h2; // support register a
   localparam logic [2:0]  IDX_SUP_B   = 3'h3; // support register b
   localparam logic [2:0]  IDX_SET     = 3'h4; // bit set op on control
   localparam logic [2:0]  IDX_CLR     = 3'h5; // bit clear op on control

   // ***********************************************************
   // control register fields
   // ***********************************************************
   localparam int          BIT_RUN     = 0;  // run or underflow flag
   localparam int          BIT_PEND_A  = 1;
   localparam int          BIT_PEND_B  = 2;
   localparam int          BIT_EN_A    = 3;
   localparam int          BIT_EN_B    = 4;
   localparam int          BIT_MODE_LO = 5;  // mode bits 1..3 at 5..7
   localparam int          BIT_FAST    = 8;  // fast select
   localparam int          CTRL_W      = 9;
   localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

   // ***********************************************************
   // mode codes as {mode_bit_3, mode_bit_2, mode_bit_1}
   // ***********************************************************
   localparam logic [2:0]  MODE_EVT_RISE = 3'h0;
   localparam logic [2:0]  MODE_EVT_FALL = 3'h1;
   localparam logic [2:0]  MODE_PWM_NOTG = 3'h4;
   localparam logic [2:0]  MODE_PWM_TOGL = 3'h5;

   // ***********************************************************
   // bus and timing
   // ***********************************************************
   localparam logic [2:0]  HSIZE_WORD  = 3'h2;
   localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
   localparam int          CLK_HZ      = 25000000;
   localparam int          INST_DIV    = 10; // master clocks per instr
   localparam logic [15:0] COUNT_RST   = 16'hFFFF;

endpackage

`default_nettype wire

// [verilog/dcrtm_edge_if.sv]
// Purpose: carries pin levels, counting tick and edge pulses
// Assumes: one clock domain
// Notes:   edges are valid only in cycles where tick is high
`default_nettype none

interface dcrtm_edge_if;
   logic tick;
   logic pin_a;
   logic pin_b;
   logic rise_a;
   logic fall_a;
   logic rise_b;
   logic fall_b;

   modport sampler (input tick, pin_a, pin_b,
                    output rise_a, fall_a, rise_b, fall_b);
   modport user    (output tick, pin_a, pin_b,
                    input rise_a, fall_a, rise_b, fall_b);
endinterface

`default_nettype wire

// [verilog/dcrtm_edge_sampler.sv]
// Purpose: samples both timer pins at the counting rate, finds edges
// Assumes: pins are synchronous to the system clock
// Notes:   a pulse shorter than one counting tick may be missed
`default_nettype none

module dcrtm_edge_sampler (
   // clock and reset
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst_n,
   // pins and edges
   dcrtm_edge_if.sampler      edges
);

   typedef struct packed {
      logic prev_a;
      logic prev_b;
   } dcrtm_smp_t;

   dcrtm_smp_t st;
   dcrtm_smp_t next_st;

   // ***********************************************************
   // edge detection
   // ***********************************************************
   // sampling only on tick ties edges to the counting clock
   always_comb begin
      next_st = st;
      if (edges.tick) begin
         next_st.prev_a = edges.pin_a;
         next_st.prev_b = edges.pin_b;
      end
   end

   // state register
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // pulses qualified by the tick
   assign edges.rise_a = edges.tick & edges.pin_a & ~st.prev_a;
   assign edges.fall_a = edges.tick & ~edges.pin_a & st.prev_a;
   assign edges.rise_b = edges.tick & edges.pin_b & ~st.prev_b;
   assign edges.fall_b = edges.tick & ~edges.pin_b & st.prev_b;

endmodule

`default_nettype wire

// [verification/dcrtm_timer_sva.sv]
// Purpose: port-level checks for the dual reload capture timer
// Assumes: bound to dcrtm_timer, one clock domain
// Notes:   register effects show two edges after the address phase
`default_nettype none

module dcrtm_timer_sva #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst_n,
   // bus
   input  wire logic              i_hsel,
   input  wire logic [ADDR_W-1:0] i_haddr,
   input  wire logic [1:0]        i_htrans,
   input  wire logic              i_hwrite,
   input  wire logic [2:0]        i_hsize,
   input  wire logic [31:0]       i_hwdata,
   input  wire logic              i_hready,
   input  wire logic [31:0]       o_hrdata,
   input  wire logic              o_hreadyout,
   input  wire logic              o_hresp,
   // pins and requests
   input  wire logic              i_timer_pin_a,
   input  wire logic              o_timer_pin_a,
   input  wire logic              o_timer_pin_a_oe,
   input  wire logic              i_timer_pin_b,
   input  wire logic              o_irq_a,
   input  wire logic              o_irq_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_take;
   logic rd_take;
   // *************************
   // transfer decode
   // *************************
   // only taken transfers may clear flags or move read data
   assign wr_take = i_hsel & i_hready & i_htrans[1] & i_hwrite;
   assign rd_take = i_hsel & i_hready & i_htrans[1] & ~i_hwrite;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // *************************
   // assertions
   // *************************
   AST_READY: assert property (o_hreadyout)
      else $error("slave not ready");
   AST_OKAY: assert property (!o_hresp)
      else $error("error response seen");
   AST_RST_QUIET: assert property ($rose(i_rst_n) |->
      (!o_irq_a && !o_irq_b && !o_timer_pin_a_oe) [*2])
      else $error("outputs active right after reset");
   AST_RDATA_HOLD: assert property (!$past(rd_take) |->
      $stable(o_hrdata))
      else $error("read data moved without a read");
   // pending flags are cleared by software only, never by hardware
   AST_IRQA_FALL: assert property ($fell(o_irq_a) |->
      $past(wr_take, 2))
      else $error("irq a dropped without a write");
   AST_IRQB_FALL: assert property ($fell(o_irq_b) |->
      $past(wr_take, 2))
      else $error("irq b dropped without a write");
   AST_OE_MODE: assert property ($changed(o_timer_pin_a_oe) |->
      $past(wr_take, 2))
      else $error("pin a enable moved without a write");
   AST_PIN_TOGGLE: assert property ($changed(o_timer_pin_a) |->
      o_timer_pin_a_oe || $past(o_timer_pin_a_oe))
      else $error("pin a toggled while not driven");
endmodule

`default_nettype wire

// [verification/dcrtm_pin_src.sv]
// Purpose: far-side source of the two timer pin levels
// Assumes: sources are synchronous to the system clock
// Notes:   pins are always driven, so no floating level is modelled
`default_nettype none

module dcrtm_pin_src (
   // clock
   input  wire logic i_sys_clk,
   // wanted levels
   input  wire logic i_want_a,
   input  wire logic i_want_b,
   // pin levels
   output var  logic o_pin_a = 1'b0,
   output var  logic o_pin_b = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // levels move just after an edge, never mid-cycle
   always @(posedge i_sys_clk) begin
      o_pin_a <= i_want_a;
      o_pin_b <= i_want_b;
   end
endmodule

`default_nettype wire

// [verification/tb_top.sv]
// Purpose: self-checking bench for the capture timer
// Assumes: zero wait state slave, pins synchronous to the clock
// Notes:   tick divider cut to 2; capture values checked by bounds
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int H = 8; // pin hold, four ticks at divider 2
   typedef struct packed {
      logic [2:0]  wi;
      logic [31:0] wd;
      logic [2:0]  ri;
      logic [31:0] ex;
      logic [1:0]  irq;
   } dcrtm_row_t;
   // write index, data, read index, expected, {irq_a, irq_b}
   localparam dcrtm_row_t ROWS [8] = '{
      '{3'h1, 32'h1234, 3'h1, 32'h1234, 2'h0},
      '{3'h2, 32'h00AA, 3'h2, 32'h00AA, 2'h0},
      '{3'h3, 32'h00BB, 3'h3, 32'h00BB, 2'h0},
      '{3'h0, 32'h0018, 3'h0, 32'h0018, 2'h0},
      '{3'h4, 32'h0006, 3'h0, 32'h001E, 2'h3},
      '{3'h5, 32'h0008, 3'h0, 32'h0016, 2'h1},
      '{3'h5, 32'h01FF, 3'h0, 32'h0000, 2'h0},
      '{3'h6, 32'h0040, 3'h4, 32'h0000, 2'h0}
   };
   localparam logic [2:0] CAPS [4] = '{3'h2, 3'h6, 3'h3, 3'h7};
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        want_a = 1'b0;
   logic        want_b = 1'b0;
   int          error_cnt = 0;
   int          n_compared = 0;
   wire  logic [31:0] hrdata;
   wire  logic  hready, hresp, pa_out, pa_oe;
   wire  logic  irq_a, irq_b, src_a, src_b, pin_a;
   // the driven pwm level wins over the source while enabled
   assign pin_a = pa_oe ? pa_out : src_a;
   // clock of 40 ns
   always #20 clk = ~clk;
   dcrtm_timer #(.INST_DIV(2), .ADDR_W(12)) u_dut (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(dcrtm_pkg::HSIZE_WORD), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .i_timer_pin_a(pin_a), .o_timer_pin_a(pa_out),
      .o_timer_pin_a_oe(pa_oe), .i_timer_pin_b(src_b),
      .o_irq_a(irq_a), .o_irq_b(irq_b));
   dcrtm_pin_src u_src (.i_sys_clk(clk), .i_want_a(want_a),
      .i_want_b(want_b), .o_pin_a(src_a), .o_pin_b(src_b));
   // *************************
   // tasks
   // *************************
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, ex);
      n_compared++;
      if (got !== ex) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one single word transfer; waits on hready in both phases
   task automatic bus(input logic w, input logic [2:0] i,
                      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {7'h00, i, 2'h0};
      htrans <= dcrtm_pkg::HTRANS_NSEQ;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [2:0] i, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, i, d, x);
   endtask
   task automatic rd(input logic [2:0] i, output logic [31:0] r);
      bus(1'b0, i, 32'h0, r);
   endtask
   task automatic rdck(input string nm, input logic [2:0] i,
                       input logic [31:0] ex);
      logic [31:0] x;
      rd(i, x);
      chk(nm, x, ex);
   endtask
   // one high pulse on pin a or, with b set, on pin b
   task automatic pulse(input logic b);
      if (b) want_b <= 1'b1; else want_a <= 1'b1;
      cyc(H);
      if (b) want_b <= 1'b0; else want_a <= 1'b0;
      cyc(H);
   endtask
   // hang guard, far beyond the few hundred cycles expected
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("watchdog expired");
      results();
   end
   // *************************
   // main sequence
   // *************************
   initial begin
      logic [31:0] v, c1, c2, sa, sb, md;
      logic        fa, fb, p;
      int          n;
      int          tg [4];
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      cyc(3);
      foreach (ROWS[k]) begin
         wr(ROWS[k].wi, ROWS[k].wd);
         rd(ROWS[k].ri, v);
         chk("reg", v, ROWS[k].ex);
         chk("irq", {irq_a, irq_b}, ROWS[k].irq);
      end
      $display("table done");
      // a reset in mid-run restores control, count and support a
      rst_n <= 1'b0;
      cyc(4);
      rst_n <= 1'b1;
      cyc(3);
      rdck("rst ctrl", 3'h0, 32'h0);
      rdck("rst count", 3'h1, 32'hFFFF);
      rdck("rst sup a", 3'h2, 32'h0);
      $display("reset done");
      // event count on each polarity, halted pulse ignored
      for (int m = 0; m < 2; m++) begin
         md = 32'(m) << 5;
         wr(3'h1, 32'h1);
         wr(3'h0, md | 32'h8);
         pulse(1'b0);
         rdck("halted", 3'h1, 32'h1);
         wr(3'h4, 32'h1);
         pulse(1'b0);
         pulse(1'b0);
         pulse(1'b1);
         rdck("evt count", 3'h1, 32'hFFFF);
         rdck("evt ctrl", 3'h0, md | 32'hF);
         chk("evt irq", {31'h0, irq_a}, 32'h1);
      end
      $display("event done");
      // capture: wrong edge first, then the selected edge
      foreach (CAPS[k]) begin
         md = {24'h0, CAPS[k], 5'h0};
         fa = CAPS[k][0];
         fb = CAPS[k][2];
         wr(3'h0, 32'h0);
         want_a <= !fa;
         want_b <= !fb;
         cyc(H);
         wr(3'h2, 32'h0);
         wr(3'h3, 32'h0);
         wr(3'h1, 32'h8000);
         wr(3'h0, md | 32'h118);
         want_a <= fa;
         want_b <= fb;
         cyc(H);
         rdck("wrong edge", 3'h0, md | 32'h118);
         rd(3'h1, c1);
         want_a <= !fa;
         want_b <= !fb;
         cyc(H);
         rd(3'h2, sa);
         rd(3'h3, sb);
         rd(3'h1, c2);
         chk("cap a", 32'(c1 > sa && sa > c2), 32'h1);
         chk("cap b", 32'(c1 > sb && sb > c2), 32'h1);
         rdck("cap ctrl", 3'h0, md | 32'h11E);
         chk("cap irq", {irq_a, irq_b}, 32'h3);
      end
      // underflow in capture shows in the run flag only
      wr(3'h0, 32'h0);
      wr(3'h1, 32'h10);
      wr(3'h0, 32'h148);
      cyc(40);
      rdck("underflow", 3'h0, 32'h149);
      chk("uf irq", {31'h0, irq_a}, 32'h1);
      wr(3'h5, 32'h8);
      cyc(1);
      chk("uf masked", {31'h0, irq_a}, 32'h0);
      $display("capture done");
      // toggling pwm: spans alternate a plus one, b plus one
      wr(3'h0, 32'h0);
      wr(3'h2, 32'h3);
      wr(3'h3, 32'h5);
      wr(3'h1, 32'h1);
      wr(3'h0, 32'h1B9);
      p = pa_out;
      n = 0;
      for (int t = 0; t < 40; t++) begin
         @(posedge clk);
         if (pa_out !== p && n < 4) begin
            tg[n] = t;
            n++;
         end
         p = pa_out;
      end
      chk("oe", {31'h0, pa_oe}, 32'h1);
      chk("a span", 32'(tg[1] - tg[0]), 32'h4);
      chk("b span", 32'(tg[2] - tg[1]), 32'h6);
      chk("a again", 32'(tg[3] - tg[2]), 32'h4);
      rdck("pwm ctrl", 3'h0, 32'h1BF);
      wr(3'h0, 32'h199);
      cyc(1);
      p = pa_out;
      cyc(30);
      chk("no toggle", {31'h0, pa_out}, {31'h0, p});
      chk("oe off", {31'h0, pa_oe}, 32'h0);
      $display("pwm done");
      results();
   end
endmodule

bind dcrtm_timer dcrtm_timer_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

`default_nettype wire
